// file: rtl/afaop_pkg.sv
// Package for the file-operand add and AND execute datapath
package afaop_pkg;
	localparam int DATA_W      = 8;
	localparam int INSN_W      = 12;
	localparam int FADDR_W     = 5;
	localparam int FADDR_LSB   = 0;
	localparam int DEST_BIT    = 5;
	localparam int OPC_LSB     = 6;
	localparam int OPC_W       = 6;
	localparam int NIB_W       = 4;
	localparam logic [OPC_W-1:0] OPC_ADD_FILE = 6'h07;
	localparam logic [OPC_W-1:0] OPC_AND_FILE = 6'h05;
	localparam logic [DATA_W-1:0] W_RESET     = 8'h00;
	localparam logic DEST_WORKING = 1'b0;
	localparam logic DEST_FILE    = 1'b1;
	typedef enum {AFA_OP_NONE, AFA_OP_ADD, AFA_OP_AND} afaop_op_e;
endpackage

// file: rtl/afaop_alu_if.sv
// Interface between the execute control and the arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface afaop_alu_if;
	import afaop_pkg::*;
	afaop_op_e         op;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] b;
	logic [DATA_W-1:0] res;
	logic              carry;
	logic              dcarry;
	logic              zero;
	modport ctrl (output op, output a, output b, input res, input carry, input dcarry, input zero);
	modport alu  (input op, input a, input b, output res, output carry, output dcarry, output zero);
endinterface
`default_nettype wire

// file: rtl/afaop_alu.sv
// Combinational add and AND unit with flag generation
`timescale 1ns/1ns
`default_nettype none
module afaop_alu (
	afaop_alu_if.alu alu
);
	import afaop_pkg::*;
	logic [DATA_W:0]  sum;
	logic [NIB_W:0]   low_sum;

	always_comb begin
		sum     = {1'b0, alu.a} + {1'b0, alu.b};
		low_sum = {1'b0, alu.a[NIB_W-1:0]} + {1'b0, alu.b[NIB_W-1:0]};
		unique case (alu.op)
			AFA_OP_ADD: alu.res = sum[DATA_W-1:0];
			AFA_OP_AND: alu.res = alu.a & alu.b;
			default:    alu.res = '0;
		endcase
		alu.carry  = sum[DATA_W];
		alu.dcarry = low_sum[NIB_W];
		alu.zero   = (alu.res == '0);
	end
endmodule
`default_nettype wire

// file: rtl/afaop_top.sv
// Execute stage for add-working-to-file and and-working-with-file
//
// Notes on behaviour
// - Add-to-file opcode adds working and file register; updates carry, digit carry, zero.
// - Destination bit zero sends the result of either operation to the working register.
// - Destination bit one writes the file register and keeps the working register.
// - AND-with-file opcode ANDs working and file register; updates only zero flag.
`timescale 1ns/1ns
`default_nettype none
module afaop_top
	import afaop_pkg::*;
(
	input  wire logic                          I_CLK,
	input  wire logic                          I_RSTN,
	input  wire logic                          I_EXEC,
	input  wire logic [afaop_pkg::INSN_W-1:0]  I_INSN,
	input  wire logic [afaop_pkg::DATA_W-1:0]  I_FILE_RDATA,
	output logic      [afaop_pkg::FADDR_W-1:0] O_FILE_ADDR,
	output logic                               O_FILE_WE,
	output logic      [afaop_pkg::DATA_W-1:0]  O_FILE_WDATA,
	output logic      [afaop_pkg::DATA_W-1:0]  O_W,
	output logic                               O_CARRY_WE,
	output logic                               O_CARRY,
	output logic                               O_DIGIT_CARRY_FLAG_WE,
	output logic                               O_DIGIT_CARRY_FLAG,
	output logic                               O_ZERO_WE,
	output logic                               O_ZERO,
	output logic                               O_DONE
);
	import afaop_pkg::*;

	afaop_alu_if        alu_bus ();
	afaop_op_e          op;
	logic               dest;
	logic [DATA_W-1:0]  w_q;
	logic [FADDR_W-1:0] faddr_q;
	logic               file_we_q;
	logic [DATA_W-1:0]  wdata_q;
	logic               c_q;
	logic               c_we_q;
	logic               dc_q;
	logic               dc_we_q;
	logic               z_q;
	logic               z_we_q;
	logic               done_q;

	////////////////////////////////////////////////////////////////////////
	// Decode
	// Words that are not taken leave W, write address and data and the flags as they are, and drop every strobe
	always_comb begin
		op = AFA_OP_NONE;
		if (I_EXEC && I_INSN[OPC_LSB +: OPC_W] == OPC_ADD_FILE)
			op = AFA_OP_ADD;
		else if (I_EXEC && I_INSN[OPC_LSB +: OPC_W] == OPC_AND_FILE)
			op = AFA_OP_AND;
	end
	assign dest        = I_INSN[DEST_BIT];
	assign O_FILE_ADDR = I_INSN[FADDR_LSB +: FADDR_W];
	assign alu_bus.op  = op;
	assign alu_bus.a   = w_q;
	assign alu_bus.b   = I_FILE_RDATA;

	// Adder and AND share one operand path
	afaop_alu u_alu (
		.alu (alu_bus)
	);

	////////////////////////////////////////////////////////////////////////
	// Working register
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			w_q <= W_RESET;
		end else if (op != AFA_OP_NONE && dest == DEST_WORKING) begin
			w_q <= alu_bus.res;
		end
	end

	// File write-back
	// A write that lands on the status register itself is resolved by the register file
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			file_we_q <= 1'b0;
			faddr_q   <= '0;
			wdata_q   <= '0;
		end else begin
			file_we_q <= (op != AFA_OP_NONE) && dest == DEST_FILE;
			if (op != AFA_OP_NONE) begin
				faddr_q <= O_FILE_ADDR;
				wdata_q <= alu_bus.res;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Carry flag, written by add only
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			c_we_q <= 1'b0;
			c_q    <= 1'b0;
		end else begin
			c_we_q <= (op == AFA_OP_ADD);
			if (op == AFA_OP_ADD) begin
				c_q <= alu_bus.carry;
			end
		end
	end

	// Digit carry, carry out of the low nibble, add only
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			dc_we_q <= 1'b0;
			dc_q    <= 1'b0;
		end else begin
			dc_we_q <= (op == AFA_OP_ADD);
			if (op == AFA_OP_ADD) begin
				dc_q <= alu_bus.dcarry;
			end
		end
	end

	// Zero flag, written by both operations
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			z_we_q <= 1'b0;
			z_q    <= 1'b0;
		end else begin
			z_we_q <= (op != AFA_OP_NONE);
			if (op != AFA_OP_NONE) begin
				z_q <= alu_bus.zero;
			end
		end
	end

	// Completion strobe, one per executed word
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (op != AFA_OP_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign O_W                   = w_q;
	assign O_FILE_WE             = file_we_q;
	assign O_FILE_WDATA          = wdata_q;
	assign O_CARRY               = c_q;
	assign O_CARRY_WE            = c_we_q;
	assign O_DIGIT_CARRY_FLAG    = dc_q;
	assign O_DIGIT_CARRY_FLAG_WE = dc_we_q;
	assign O_ZERO                = z_q;
	assign O_ZERO_WE             = z_we_q;
	assign O_DONE                = done_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Expected values are rebuilt from the operands, not taken from the unit
	chk_add_result: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_ADD) |=> (O_FILE_WDATA == 8'(($past(w_q) + $past(I_FILE_RDATA)))))
		else $error("add result wrong");
	chk_add_carry: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_ADD) |=> O_CARRY_WE && O_DIGIT_CARRY_FLAG_WE && O_ZERO_WE
		&& O_CARRY == ((9'($past(w_q)) + 9'($past(I_FILE_RDATA))) > 9'h0ff))
		else $error("add flags wrong");
	chk_add_dcarry: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_ADD) |=> O_DIGIT_CARRY_FLAG ==
		((5'($past(w_q[NIB_W-1:0])) + 5'($past(I_FILE_RDATA[NIB_W-1:0]))) > 5'h0f))
		else $error("add digit carry wrong");
	chk_add_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_ADD) |=> O_ZERO == (8'($past(w_q) + $past(I_FILE_RDATA)) == 8'h00))
		else $error("add zero wrong");
	chk_add_working: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_ADD && !dest) |=> O_W == 8'($past(w_q) + $past(I_FILE_RDATA)))
		else $error("add to working wrong");

	// Destination select
	chk_dest_working: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op != AFA_OP_NONE && !dest) |=> (O_W == O_FILE_WDATA) && !O_FILE_WE)
		else $error("working destination wrong");
	chk_dest_file: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op != AFA_OP_NONE && dest) |=> O_FILE_WE && $stable(O_W)
		&& (O_FILE_WDATA == (($past(op) == AFA_OP_ADD)
		? 8'($past(w_q) + $past(I_FILE_RDATA))
		: ($past(w_q) & $past(I_FILE_RDATA)))))
		else $error("file destination wrong");
	chk_and_flags: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_AND) |=> !O_CARRY_WE && !O_DIGIT_CARRY_FLAG_WE && O_ZERO_WE
		&& O_ZERO == (($past(w_q) & $past(I_FILE_RDATA)) == 8'h00) && $stable(O_CARRY)
		&& $stable(O_DIGIT_CARRY_FLAG))
		else $error("and flags wrong");
	chk_and_working: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_AND && !dest) |=> O_W == ($past(w_q) & $past(I_FILE_RDATA)))
		else $error("and result wrong");

	// Timing and refused words
	chk_one_cycle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op != AFA_OP_NONE) |=> O_DONE ##1 (O_DONE == $past(op != AFA_OP_NONE)))
		else $error("done timing wrong");
	chk_idle_quiet: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_NONE) |=> !O_FILE_WE && !O_ZERO_WE && $stable(O_W))
		else $error("idle write seen");
	chk_idle_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op == AFA_OP_NONE) |=> !O_DONE && !O_CARRY_WE && !O_DIGIT_CARRY_FLAG_WE
		&& $stable(O_FILE_WDATA) && $stable(O_CARRY) && $stable(O_DIGIT_CARRY_FLAG)
		&& $stable(O_ZERO))
		else $error("refused word changed state");
	chk_done_strobes: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(O_DONE == O_ZERO_WE) && (O_CARRY_WE == O_DIGIT_CARRY_FLAG_WE) && (!O_CARRY_WE || O_DONE))
		else $error("strobe set inconsistent");
	chk_wb_addr: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		(op != AFA_OP_NONE && dest) |=> faddr_q == $past(I_INSN[FADDR_LSB +: FADDR_W]))
		else $error("write address wrong");

	// Main scenarios
	cov_add_w: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		op == AFA_OP_ADD && !dest);
	cov_and_file: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		op == AFA_OP_AND && dest);
	cov_add_f_carry: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		op == AFA_OP_ADD && dest && alu_bus.carry);
	cov_and_zero: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		op == AFA_OP_AND && alu_bus.zero);
	cov_back2back: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
		op != AFA_OP_NONE ##1 op != AFA_OP_NONE);
endmodule
`default_nettype wire

// file: tb/afaop_rf_model.sv
// Behavioural file register model facing the execute stage
`timescale 1ns/1ns
`default_nettype none
module afaop_rf_model (
	input  wire logic       clk,
	input  wire logic [4:0] i_addr,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_ld,
	input  wire logic [4:0] i_ld_addr,
	input  wire logic [7:0] i_ld_data,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem [32];
	logic [4:0] addr_q;
	initial for (int k = 0; k < 32; k++) mem[k] <= 8'(k * 29 + 3);
	// Read follows the address at once
	assign o_rdata = mem[i_addr];
	// Write lands one cycle later at the address of the taken word; a preload wins
	always @(posedge clk) begin
		addr_q <= i_addr;
		if (i_we) mem[addr_q] <= i_wdata;
		if (i_ld) mem[i_ld_addr] <= i_ld_data;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Random and corner-case bench for the add and AND execute stage
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import afaop_pkg::*;
	logic clk = 0, rstn = 0, exec = 0;
	logic [INSN_W-1:0] insn = '0;
	logic [DATA_W-1:0] rd, wdat, w, ew = W_RESET;
	logic [FADDR_W-1:0] fa;
	logic fwe, cwe, c, dwe, dc, zwe, z, done;
	logic ld = 0;
	logic [FADDR_W-1:0] ld_a = '0;
	logic [DATA_W-1:0] ld_d = '0;
	int n_fail = 0, total_checks = 0;
	always #2 clk = ~clk;
	afaop_top afaop_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_EXEC(exec), .I_INSN(insn),
		.I_FILE_RDATA(rd), .O_FILE_ADDR(fa), .O_FILE_WE(fwe), .O_FILE_WDATA(wdat),
		.O_W(w), .O_CARRY_WE(cwe), .O_CARRY(c), .O_DIGIT_CARRY_FLAG_WE(dwe),
		.O_DIGIT_CARRY_FLAG(dc), .O_ZERO_WE(zwe), .O_ZERO(z), .O_DONE(done));
	afaop_rf_model afaop_rf_model_inst (.clk(clk), .i_addr(fa), .i_we(fwe),
		.i_wdata(wdat), .i_ld(ld), .i_ld_addr(ld_a), .i_ld_data(ld_d), .o_rdata(rd));
	////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (e !== g) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Preloads one file register over an idle cycle
	task automatic load(logic [4:0] a, logic [7:0] d);
		exec = 0;
		ld = 1;
		ld_a = a;
		ld_d = d;
		@(posedge clk) #1;
		ld = 0;
	endtask
	// Drives one word, then checks the answer one cycle later
	task automatic op(logic e, logic [11:0] i);
		logic [7:0] f, r;
		logic [8:0] s;
		logic [4:0] h;
		logic ad, an;
		exec = e;
		insn = i;
		#1 f = rd;
		chk("file_addr", i[4:0], fa);
		ad = e && i[11:6] == OPC_ADD_FILE;
		an = e && i[11:6] == OPC_AND_FILE;
		s = ew + f;
		h = ew[3:0] + f[3:0];
		r = ad ? s[7:0] : ew & f;
		@(posedge clk) #1;
		chk("done", ad | an, done);
		chk("file_we", (ad | an) & i[5], fwe);
		chk("carry_we", ad, cwe);
		chk("dc_we", ad, dwe);
		chk("zero_we", ad | an, zwe);
		if (ad) chk("carry", s[8], c);
		if (ad) chk("dc", h[4], dc);
		if (ad | an) chk("zero", r == 8'h00, z);
		if ((ad | an) & i[5]) chk("file_wdata", r, wdat);
		if ((ad | an) & !i[5]) ew = r;
		chk("w", ew, w);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [11:0] i;
		void'($urandom(7));
		repeat (5) @(posedge clk);
		#1 rstn = 1;
		load(5'h03, 8'h17);
		op(1, 12'h1c3);
		load(5'h03, 8'hc2);
		op(1, 12'h1c3);
		op(1, 12'h163);
		load(5'h04, 8'h27);
		op(1, 12'h1c4);
		op(0, 12'h1e4);
		op(1, 12'h0e4);
		op(1, 12'h17f);
		repeat (300) begin
			i[11:6] = $urandom % 4 == 0 ? 6'($urandom)
				: ($urandom % 2 ? OPC_ADD_FILE : OPC_AND_FILE);
			i[5:0] = 6'($urandom);
			op($urandom % 8 != 0, i);
		end
		exec = 0;
		results();
	end
	initial begin
		#20000;
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
